// file: core/drive_line_decode.sv
// Drive select and motor line decode for two drives, normal or swapped order
`timescale 1ns/100ps
`include "fdc_regs_cfg.svh"
module drive_line_decode (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire fdc_regs_pkg::byte_t    out_ctrl,
    input  wire logic                   swap_order,
    output logic                        drive_pick_zero_low,
    output logic                        drive_pick_one_low,
    output logic                        motor_line_zero_low,
    output logic                        motor_line_one_low
);
    fdc_regs_pkg::drive_code_t sel;
    logic                      mot0;
    logic                      mot1;
    logic                      pick_a;
    logic                      pick_b;

    // Code 00 needs motor 0 bit, code 01 motor 1 bit; 10/11 pick nothing
    assign sel    = out_ctrl[`OUT_SEL_MSB:`OUT_SEL_LSB];
    assign mot0   = out_ctrl[`OUT_MOTOR0_BIT];                              // see R1
    assign mot1   = out_ctrl[`OUT_MOTOR1_BIT];                              // see R1
    assign pick_a = (sel == 2'h0) && mot0;                                  // see R9
    assign pick_b = (sel == 2'h1) && mot1;                                  // see R9

    // Registered pins so the drives never see decode glitches
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            drive_pick_zero_low <= 1'b1;
            drive_pick_one_low  <= 1'b1;
            motor_line_zero_low <= 1'b1;
            motor_line_one_low  <= 1'b1;
        end else if (swap_order) begin
            drive_pick_zero_low <= ~pick_b;                                 // see R10
            drive_pick_one_low  <= ~pick_a;                                 // see R10
            motor_line_zero_low <= ~mot1;                                   // see R10
            motor_line_one_low  <= ~mot0;                                   // see R10
        end else begin
            drive_pick_zero_low <= ~pick_a;                                 // see R9
            drive_pick_one_low  <= ~pick_b;                                 // see R9
            motor_line_zero_low <= ~mot0;                                   // see R9
            motor_line_one_low  <= ~mot1;                                   // see R9
        end
    end
endmodule

// file: core/fdc_regs_cfg.svh
// Address map, field positions, reset values and timing for the drive control registers
// What this block does
// R1 - Output bit 4 runs motor zero, bit 5 motor one
// R2 - Output bits 6 and 7 always read zero
// R3 - Software writes 1CH or 2DH to start drive
// R4 - Tape select code picks none, drive 1, 2, 3
// R5 - Drive zero never gets tape support
// R6 - Accesses to tape drive use tape handling
// R7 - Normal mode read: bits 7..2 float
// R8 - Software reset keeps tape register contents
// R9 - Normal decode of selects and motor lines
// R10 - Swapped decode exchanges drives zero and one
// R11 - Enhanced mode adds boot drive, type ID fields
// R12 - Type ID picks config bit pair by select
// R13 - Rate select register is write only
// R14 - Latest rate write from either register wins
// R15 - Older systems program rate via config control
// R16 - Hardware reset loads rate select with 02H
// R17 - Software reset keeps rate select contents except the power down bit, which it clears
// R18 - Rate select bit layout: reset, power, precomp, rate
// R19 - Rate select reset bit resets, then self-clears
// R20 - Power down bit; reset or access wakes
// R21 - Strap picks swapped decode, normal after reset
`ifndef FDC_REGS_CFG_SVH
`define FDC_REGS_CFG_SVH

`define ADDR_W             10
`define ADDR_OUTPUT_CTRL   10'h3f2
`define ADDR_TAPE_ASSIGN   10'h3f3
`define ADDR_RATE_SELECT   10'h3f4
`define ADDR_DATA_PORT     10'h3f5
`define ADDR_CFG_RATE      10'h3f7

`define OUT_SEL_LSB        0
`define OUT_SEL_MSB        1
`define OUT_RESET_N_BIT    2
`define OUT_DMA_BIT        3
`define OUT_MOTOR0_BIT     4
`define OUT_MOTOR1_BIT     5
`define OUT_RESET_VAL      8'h00

`define TAPE_SEL_LSB       0
`define TAPE_SEL_MSB       1
`define TAPE_BOOT_LSB      2
`define TAPE_BOOT_MSB      3
`define TAPE_TYPE_LSB      4
`define TAPE_TYPE_MSB      5
`define TAPE_SEL_NONE      2'h0

`define RATE_CODE_LSB      0
`define RATE_CODE_MSB      1
`define RATE_SHIFT_LSB     2
`define RATE_SHIFT_MSB     4
`define RATE_PDOWN_BIT     6
`define RATE_SRST_BIT      7
`define RATE_RESET_VAL     8'h02

`define SRST_MIN_NS        100
`define CLK_PERIOD_NS      100
`define SRST_CYCLES        ((`SRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: core/fdc_regs_pkg.sv
// Shared types for the drive control registers
package fdc_regs_pkg;
    typedef logic [1:0] drive_code_t;
    typedef logic [7:0] byte_t;
    typedef enum logic {DECODE_NORMAL, DECODE_SWAPPED} decode_order_e;
    typedef enum logic {TAPE_VIEW_NORMAL, TAPE_VIEW_ENHANCED} tape_view_e;
endpackage

// file: core/floppy_drive_control_regs.sv
// Host-visible floppy drive control registers: output control, tape assign, rate select
`timescale 1ns/100ps
`include "fdc_regs_cfg.svh"
module floppy_drive_control_regs (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Host I/O bus pins
    input  wire logic [`ADDR_W-1:0]     io_addr,
    input  wire logic [7:0]             io_data_in,
    output logic      [7:0]             io_data_out,
    output logic      [7:0]             io_data_oe,
    input  wire logic                   io_rd_n,
    input  wire logic                   io_wr_n,
    // Configuration inputs from the same clock domain
    input  wire logic                   swap_drives,
    input  wire logic                   enhanced_mode,
    input  wire fdc_regs_pkg::byte_t    drive_kind_config,
    // Drive pins
    output logic                        drive_pick_zero_low,
    output logic                        drive_pick_one_low,
    output logic                        motor_line_zero_low,
    output logic                        motor_line_one_low,
    // Controller-facing state
    output logic                        dma_enable,
    output logic                        ctrl_soft_reset,
    output logic                        low_power,
    output logic      [1:0]             rate_code,
    output logic      [2:0]             write_shift,
    output logic      [1:0]             tape_drive,
    output logic      [1:0]             boot_drive,
    output logic                        tape_handling
);
    // Two-stage synchronisers for every bus pin
    logic [`ADDR_W-1:0] addr_s1_r;
    logic [`ADDR_W-1:0] addr_s2_r;
    logic [7:0]         data_s1_r;
    logic [7:0]         data_s2_r;
    logic               rd_n_s1_r;
    logic               rd_n_s2_r;
    logic               wr_n_s1_r;
    logic               wr_n_s2_r;
    logic               rd_n_d_r;
    logic               wr_n_d_r;

    // Register state
    fdc_regs_pkg::byte_t out_ctrl_r;
    logic [1:0]          tape_sel_r;
    logic [1:0]          boot_sel_r;
    logic [1:0]          rate_r;
    logic [2:0]          shift_r;
    logic                pdown_r;
    logic [3:0]          srst_cnt_r;
    logic [3:0]          srst_cnt_nxt;
    logic                swap_r;

    // Decoded strobes
    logic                wr_stb;
    logic                rd_stb;
    logic                rd_active;
    logic                soft_rst;
    logic                wake;

    fdc_regs_pkg::decode_order_e order;
    fdc_regs_pkg::tape_view_e    view;
    fdc_regs_pkg::drive_code_t   cur_sel;
    logic [1:0]                  type_id;
    fdc_regs_pkg::byte_t         rd_val;
    fdc_regs_pkg::byte_t         rd_oe;

    // Typed copy of the rate select reset word; a bare literal cannot be sliced
    localparam fdc_regs_pkg::byte_t rate_reset_word = `RATE_RESET_VAL;

    // Pins are asynchronous to clk_sys; nothing reads stage one but stage two
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_s1_r <= '0;
            addr_s2_r <= '0;
        end else begin
            addr_s1_r <= io_addr;
            addr_s2_r <= addr_s1_r;
        end
    end

    // Write data stages; the host holds data well past the strobe edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_s1_r <= 8'h00;
            data_s2_r <= 8'h00;
        end else begin
            data_s1_r <= io_data_in;
            data_s2_r <= data_s1_r;
        end
    end

    // Strobe stages reset to idle high, so no false edge follows reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_n_s1_r <= 1'b1;
            rd_n_s2_r <= 1'b1;
            wr_n_s1_r <= 1'b1;
            wr_n_s2_r <= 1'b1;
        end else begin
            rd_n_s1_r <= io_rd_n;
            rd_n_s2_r <= rd_n_s1_r;
            wr_n_s1_r <= io_wr_n;
            wr_n_s2_r <= wr_n_s1_r;
        end
    end

    // Delayed strobes for edge detection
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_n_d_r <= 1'b1;
            wr_n_d_r <= 1'b1;
        end else begin
            rd_n_d_r <= rd_n_s2_r;
            wr_n_d_r <= wr_n_s2_r;
        end
    end

    // Write takes effect on the trailing (rising) edge, when data has settled
    assign wr_stb    = wr_n_s2_r && !wr_n_d_r;
    assign rd_stb    = !rd_n_s2_r && rd_n_d_r;
    assign rd_active = !rd_n_s2_r;

    // Decode order strap, captured on a clock edge, normal from reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            swap_r <= 1'b0;                                                 // see R21
        end else begin
            swap_r <= swap_drives;                                          // see R21
        end
    end

    assign order = swap_r ? fdc_regs_pkg::DECODE_SWAPPED : fdc_regs_pkg::DECODE_NORMAL;
    assign view  = enhanced_mode ? fdc_regs_pkg::TAPE_VIEW_ENHANCED
                                 : fdc_regs_pkg::TAPE_VIEW_NORMAL;

    // Output control register; only hardware reset clears it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_ctrl_r <= `OUT_RESET_VAL;
        end else if (wr_stb && addr_s2_r == `ADDR_OUTPUT_CTRL) begin
            out_ctrl_r <= data_s2_r;                                        // see R1, R3
        end
    end

    // Tape assign register; soft reset leaves it alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tape_sel_r <= `TAPE_SEL_NONE;
        end else if (wr_stb && addr_s2_r == `ADDR_TAPE_ASSIGN) begin
            tape_sel_r <= data_s2_r[`TAPE_SEL_MSB:`TAPE_SEL_LSB];           // see R4, R8
        end
    end

    // Boot drive field only exists in the enhanced view
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            boot_sel_r <= 2'h0;
        end else if (wr_stb && addr_s2_r == `ADDR_TAPE_ASSIGN &&
                     view == fdc_regs_pkg::TAPE_VIEW_ENHANCED) begin
            boot_sel_r <= data_s2_r[`TAPE_BOOT_MSB:`TAPE_BOOT_LSB];         // see R11
        end
    end

    // Shared rate: a write to either register replaces it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rate_r <= rate_reset_word[`RATE_CODE_MSB:`RATE_CODE_LSB];       // see R16
        end else if (wr_stb && (addr_s2_r == `ADDR_RATE_SELECT ||
                                addr_s2_r == `ADDR_CFG_RATE)) begin
            rate_r <= data_s2_r[`RATE_CODE_MSB:`RATE_CODE_LSB];             // see R14, R15
        end
    end

    // Precompensation field, untouched by soft reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_r <= rate_reset_word[`RATE_SHIFT_MSB:`RATE_SHIFT_LSB];    // see R16
        end else if (wr_stb && addr_s2_r == `ADDR_RATE_SELECT) begin
            shift_r <= data_s2_r[`RATE_SHIFT_MSB:`RATE_SHIFT_LSB];          // see R13, R17, R18
        end
    end

    // Self-clearing reset pulse, held at least the minimum reset width
    always_comb begin
        srst_cnt_nxt = srst_cnt_r;
        if (wr_stb && addr_s2_r == `ADDR_RATE_SELECT && data_s2_r[`RATE_SRST_BIT]) begin
            srst_cnt_nxt = 4'(`SRST_CYCLES);                                // see R19
        end else if (srst_cnt_r != 4'h0) begin
            srst_cnt_nxt = srst_cnt_r - 4'h1;                               // see R19
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            srst_cnt_r <= 4'h0;
        end else begin
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    // Either reset source drives the controller reset
    assign soft_rst = !out_ctrl_r[`OUT_RESET_N_BIT] || (srst_cnt_r != 4'h0);  // see R19

    // Any status or data port access brings the controller out of low power
    assign wake = (rd_stb && addr_s2_r == `ADDR_RATE_SELECT) ||
                  ((rd_stb || wr_stb) && addr_s2_r == `ADDR_DATA_PORT);

    // Manual low power; a setting write in the same cycle as a wake wins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pdown_r <= 1'b0;
        end else if (wr_stb && addr_s2_r == `ADDR_RATE_SELECT &&
                     data_s2_r[`RATE_PDOWN_BIT]) begin
            pdown_r <= 1'b1;                                                // see R20
        end else if (soft_rst || wake) begin
            pdown_r <= 1'b0;                                                // see R20
        end
    end

    // Type ID: one bit pair of the drive kind config, chosen by select code
    assign cur_sel = out_ctrl_r[`OUT_SEL_MSB:`OUT_SEL_LSB];
    assign type_id = drive_kind_config[{cur_sel, 1'b0} +: 2];               // see R12

    // Read mux; rate select is write only, so its address drives nothing
    always_comb begin
        rd_val = 8'h00;
        rd_oe  = 8'h00;
        unique case (addr_s2_r)
            `ADDR_OUTPUT_CTRL: begin
                rd_val = {2'h0, out_ctrl_r[5:0]};                           // see R2
                rd_oe  = 8'hff;
            end
            `ADDR_TAPE_ASSIGN: begin
                if (view == fdc_regs_pkg::TAPE_VIEW_ENHANCED) begin
                    rd_val = {2'h0, type_id, boot_sel_r, tape_sel_r};       // see R11, R12
                    rd_oe  = 8'hff;
                end else begin
                    rd_val = {6'h00, tape_sel_r};                           // see R7
                    rd_oe  = 8'h03;                                         // see R7
                end
            end
            default: begin
                rd_val = 8'h00;                                             // see R13
                rd_oe  = 8'h00;
            end
        endcase
    end

    // Data bus drivers, registered, released when read ends
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            io_data_out <= 8'h00;
            io_data_oe  <= 8'h00;
        end else if (rd_active) begin
            io_data_out <= rd_val;
            io_data_oe  <= rd_oe;
        end else begin
            io_data_out <= 8'h00;
            io_data_oe  <= 8'h00;
        end
    end

    // Controller control outputs from flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dma_enable      <= 1'b0;
            ctrl_soft_reset <= 1'b0;
            low_power       <= 1'b0;
        end else begin
            dma_enable      <= out_ctrl_r[`OUT_DMA_BIT];
            ctrl_soft_reset <= soft_rst;                                    // see R19
            low_power       <= pdown_r;                                     // see R20
        end
    end

    // Rate outputs; one cycle behind the shared rate register and the precompensation field
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rate_code       <= 2'h0;
            write_shift     <= 3'h0;
        end else begin
            rate_code       <= rate_r;                                      // see R14
            write_shift     <= shift_r;
        end
    end

    // Tape outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tape_drive      <= 2'h0;
            boot_drive      <= 2'h0;
            tape_handling   <= 1'b0;
        end else begin
            tape_drive      <= tape_sel_r;                                  // see R4
            boot_drive      <= boot_sel_r;
            // Code 00 means none, so drive 0 can never be the tape drive
            tape_handling   <= (tape_sel_r != `TAPE_SEL_NONE) &&
                               (tape_sel_r == cur_sel);                     // see R5, R6
        end
    end

    // Select and motor pin decode
    drive_line_decode u_decode (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .out_ctrl            (out_ctrl_r),
        .swap_order          (order == fdc_regs_pkg::DECODE_SWAPPED),       // see R10, R21
        .drive_pick_zero_low (drive_pick_zero_low),
        .drive_pick_one_low  (drive_pick_one_low),
        .motor_line_zero_low (motor_line_zero_low),
        .motor_line_one_low  (motor_line_one_low)
    );
endmodule

// file: tb/drive_ctrl_props.sv
// Port-level assertions for the floppy drive control registers
`timescale 1ns/100ps
module drive_ctrl_props (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] io_data_out,
    input wire logic [7:0] io_data_oe,
    input wire logic       drive_pick_zero_low,
    input wire logic       drive_pick_one_low,
    input wire logic       motor_line_zero_low,
    input wire logic       motor_line_one_low,
    input wire logic       ctrl_soft_reset,
    input wire logic       low_power,
    input wire logic [1:0] rate_code,
    input wire logic [2:0] write_shift,
    input wire logic [1:0] tape_drive,
    input wire logic       tape_handling
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // A pick line only goes low with its own motor, in either order
    a_pick_exclusive: assert property (drive_pick_zero_low || drive_pick_one_low)
        else $error("both drive picks low");
    a_pick_zero_motor: assert property (!drive_pick_zero_low |-> !motor_line_zero_low)
        else $error("pick zero low without motor zero");
    a_pick_one_motor: assert property (!drive_pick_one_low |-> !motor_line_one_low)
        else $error("pick one low without motor one");
    // Idle lines and default rate straight after hardware reset
    a_reset_idle: assert property ($rose(rst_n) |-> drive_pick_zero_low && drive_pick_one_low
        && motor_line_zero_low && motor_line_one_low && io_data_oe == 8'h00)
        else $error("drive lines not idle after reset");
    a_rate_default: assert property ($rose(rst_n) |-> ##[1:2]
        (rate_code == 2'b10 && write_shift == 3'h0))
        else $error("rate select not at default after reset");
    // Read bus: normal tape view drives two bits only
    a_tape_readback: assert property (io_data_oe == 8'h03 |-> io_data_out == {6'h00, tape_drive})
        else $error("tape readback wrong");
    a_oe_pattern: assert property (io_data_oe inside {8'h00, 8'h03, 8'hff})
        else $error("unexpected read enable pattern");
    a_top_bits_zero: assert property (io_data_oe == 8'hff |-> io_data_out[7:6] == 2'b00)
        else $error("top read bits not zero");
    a_tape_flag: assert property (tape_handling |-> tape_drive != 2'b00)
        else $error("tape handling without tape drive");
    // Soft reset may let a fresh power down show for one cycle, never two
    a_power_wake: assert property (ctrl_soft_reset && low_power |=> !low_power)
        else $error("low power survived soft reset");

    c_tape: cover property (tape_handling);
    c_pick_one: cover property (!drive_pick_one_low);
    c_low_power: cover property (low_power);
endmodule

// file: tb/host_bus_model.sv
// Host side model: drives the I/O strobes, address and data pins
`timescale 1ns/100ps
`include "fdc_regs_cfg.svh"
module host_bus_model (
    input  wire logic                 clk_sys,
    output logic      [`ADDR_W-1:0]   io_addr,
    output logic      [7:0]           io_data_in,
    output logic                      io_rd_n,
    output logic                      io_wr_n,
    input  wire logic [7:0]           io_data_out,
    input  wire logic [7:0]           io_data_oe
);
    initial begin
        io_addr = '0;
        io_data_in = 8'ha5;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
    end

    // Strobe low four cycles; address and data held past the synchronisers
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        io_addr = a;
        io_data_in = v;
        io_wr_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        io_wr_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        io_data_in = ~v; // Released lines must not keep the old byte
    endtask

    // Data taken once sync plus output flop have settled
    task automatic rd(input logic [`ADDR_W-1:0] a, output logic [7:0] v, output logic [7:0] e);
        @(negedge clk_sys);
        io_addr = a;
        io_rd_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        v = (io_data_out & io_data_oe) | (~io_data_out & ~io_data_oe); // Undriven bits read as the inverse of io_data_out
        e = io_data_oe;
        io_rd_n = 1'b1;
        repeat (5) @(negedge clk_sys);
    endtask
endmodule

// file: tb/tb_top.sv
// Testbench top: register access sequences against the drive control block
`timescale 1ns/100ps
`include "fdc_regs_cfg.svh"
module tb_top;
    logic                 clk_sys, rst_n, io_rd_n, io_wr_n, swap_drives, enhanced_mode, seen;
    logic [`ADDR_W-1:0]   io_addr;
    logic [7:0]           io_data_in, io_data_out, io_data_oe, d, oe;
    fdc_regs_pkg::byte_t  drive_kind_config;
    logic                 drive_pick_zero_low, drive_pick_one_low;
    logic                 motor_line_zero_low, motor_line_one_low;
    logic                 dma_enable, ctrl_soft_reset, low_power, tape_handling;
    logic [1:0]           rate_code, tape_drive, boot_drive;
    logic [2:0]           write_shift;
    int                   miscompares, checks_done, cycles;
    logic [7:0]           dv [6] = '{8'h1c, 8'h2d, 8'h4e, 8'h1c, 8'h2d, 8'hdc};
    logic [7:0]           pe [6] = '{8'h0a, 8'h05, 8'h0f, 8'h05, 8'h0a, 8'h0a};
    logic                 sw [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    floppy_drive_control_regs u_floppy_drive_control_regs (
        .clk_sys(clk_sys), .rst_n(rst_n), .io_addr(io_addr), .io_data_in(io_data_in),
        .io_data_out(io_data_out), .io_data_oe(io_data_oe), .io_rd_n(io_rd_n),
        .io_wr_n(io_wr_n), .swap_drives(swap_drives), .enhanced_mode(enhanced_mode),
        .drive_kind_config(drive_kind_config), .drive_pick_zero_low(drive_pick_zero_low),
        .drive_pick_one_low(drive_pick_one_low), .motor_line_zero_low(motor_line_zero_low),
        .motor_line_one_low(motor_line_one_low), .dma_enable(dma_enable),
        .ctrl_soft_reset(ctrl_soft_reset), .low_power(low_power), .rate_code(rate_code),
        .write_shift(write_shift), .tape_drive(tape_drive), .boot_drive(boot_drive),
        .tape_handling(tape_handling));
    host_bus_model u_host_bus_model (
        .clk_sys(clk_sys), .io_addr(io_addr), .io_data_in(io_data_in), .io_rd_n(io_rd_n),
        .io_wr_n(io_wr_n), .io_data_out(io_data_out), .io_data_oe(io_data_oe));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Drive pins packed as pick one, pick zero, motor one, motor zero
    task automatic pins(input logic [7:0] e);
        chk("pins", e, {4'h0, drive_pick_one_low, drive_pick_zero_low,
            motor_line_one_low, motor_line_zero_low});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Whole run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        swap_drives = 1'b0;
        enhanced_mode = 1'b0;
        drive_kind_config = 8'he4;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("rate", 8'h02, {6'h00, rate_code});
        pins(8'h0f);
        // Decode table, normal and swapped order
        for (int i = 0; i < 6; i++) begin
            swap_drives = sw[i];
            u_host_bus_model.wr(10'h3f2, dv[i]);
            pins(pe[i]);
        end
        u_host_bus_model.rd(10'h3f2, d, oe);
        chk("dor", 8'h1c, d);
        chk("dma", 8'h01, {7'h00, dma_enable});
        // Tape select codes; drive zero never gets tape handling
        for (int t = 0; t < 4; t++) begin
            u_host_bus_model.wr(10'h3f3, 8'hfc | t[7:0]);
            u_host_bus_model.rd(10'h3f3, d, oe);
            chk("tdr_oe", 8'h03, oe);
            chk("tdr", t[7:0], d & 8'h03);
            u_host_bus_model.wr(10'h3f2, 8'h0c | t[7:0]);
            chk("tape_on", {7'h00, t != 0}, {7'h00, tape_handling});
        end
        // Soft reset through output control keeps tape and rate
        u_host_bus_model.wr(10'h3f2, 8'h00);
        chk("srst", 8'h01, {7'h00, ctrl_soft_reset});
        u_host_bus_model.rd(10'h3f3, d, oe);
        chk("tdr_keep", 8'h03, d & 8'h03);
        chk("tdr_keep_oe", 8'h03, oe);
        chk("rate_keep", 8'h02, {6'h00, rate_code});
        u_host_bus_model.wr(10'h3f4, 8'h42);
        chk("lp_srst", 8'h00, {7'h00, low_power});
        enhanced_mode = 1'b1;
        u_host_bus_model.wr(10'h3f3, 8'h0d);
        for (int s = 0; s < 4; s++) begin
            u_host_bus_model.wr(10'h3f2, 8'h0c | s[7:0]);
            u_host_bus_model.rd(10'h3f3, d, oe);
            chk("tdr_enh", {2'b00, drive_kind_config[2*s +: 2], 4'hd}, d);
        end
        chk("boot", 8'h03, {6'h00, boot_drive});
        // Rate from either register, most recent wins
        u_host_bus_model.wr(10'h3f4, 8'h1d);
        chk("shift", 8'h07, {5'h00, write_shift});
        chk("rate1", 8'h01, {6'h00, rate_code});
        u_host_bus_model.wr(10'h3f7, 8'h03);
        chk("rate3", 8'h03, {6'h00, rate_code});
        u_host_bus_model.wr(10'h3f4, 8'h5e);
        chk("lp", 8'h01, {7'h00, low_power});
        chk("rate2", 8'h02, {6'h00, rate_code});
        u_host_bus_model.rd(10'h3f4, d, oe);
        chk("dsr_oe", 8'h00, oe);
        chk("lp_wake", 8'h00, {7'h00, low_power});
        seen = 1'b0;
        fork
            u_host_bus_model.wr(10'h3f4, 8'h81);
            repeat (12) @(negedge clk_sys) if (ctrl_soft_reset === 1'b1) seen = 1'b1;
        join
        chk("pulse", 8'h01, {7'h00, seen});
        chk("selfclr", 8'h00, {7'h00, ctrl_soft_reset});
        chk("rate_kept", 8'h01, {6'h00, rate_code});
        u_host_bus_model.wr(10'h3f0, 8'hff);
        u_host_bus_model.rd(10'h3f0, d, oe);
        chk("unmapped", 8'h00, oe);
        stop_test();
    end
endmodule

bind floppy_drive_control_regs drive_ctrl_props u_drive_ctrl_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_data_out(io_data_out), .io_data_oe(io_data_oe),
    .drive_pick_zero_low(drive_pick_zero_low), .drive_pick_one_low(drive_pick_one_low),
    .motor_line_zero_low(motor_line_zero_low), .motor_line_one_low(motor_line_one_low),
    .ctrl_soft_reset(ctrl_soft_reset), .low_power(low_power), .rate_code(rate_code),
    .write_shift(write_shift), .tape_drive(tape_drive), .tape_handling(tape_handling));
